// ### hdl/rx_status_pkg.sv
// constants, field layouts and state codes of the serial receiver status block
// assumes a single clock domain and the plain register port of the top module
package rx_status_pkg;
    localparam logic [4:0] ctrl1_off   = 5'h00;
    localparam logic [4:0] ctrl2_off   = 5'h04;
    localparam logic [4:0] ctrl3_off   = 5'h08;
    localparam logic [4:0] status1_off = 5'h0c;
    localparam logic [4:0] data_off    = 5'h10;
    localparam logic [4:0] baud_off    = 5'h14;

    localparam logic [7:0] baud_reset  = 8'h00;
    localparam logic [4:0] rt_last     = 5'h10;
    localparam logic [4:0] rt_stop     = 5'h0a;
    localparam logic [4:0] rt_resync   = 5'h02;
    localparam logic [4:0] rt_late_max = 5'h04;
    localparam logic [4:0] rt_early    = 5'h0d;
    localparam logic [7:0] idle_len8   = 8'ha0;
    localparam logic [7:0] idle_len9   = 8'hb0;

    // control register one, bits 5..0
    typedef struct packed {
        logic enable;
        logic nine_bit;
        logic wake_sel;
        logic idle_type_bit;
        logic parity_en;
        logic parity_odd;
    } ctrl1_t;

    // control register two, bits 3..0
    typedef struct packed {
        logic receive_full_irq_enable;
        logic idle_irq_enable;
        logic rx_enable;
        logic standby_request_bit;
    } ctrl2_t;

    // control register three, bits 3..0
    typedef struct packed {
        logic overrun_irq_enable;
        logic noise_irq_enable;
        logic framing_irq_enable;
        logic parity_irq_enable;
    } ctrl3_t;

    // status register one, bits 5..0
    typedef struct packed {
        logic receiver_full_flag;
        logic idle_line_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_error_flag;
        logic parity_error_flag;
    } status_t;

    typedef enum logic [3:0] {
        hunt_s  = 4'h1,
        start_s = 4'h2,
        data_s  = 4'h4,
        stop_s  = 4'h8
    } rx_state_t;
endpackage

// ### hdl/serial_rx_status.sv
// receiver datapath, status flags and interrupt requests of the serial interface
// assumes rx_line and all control inputs are synchronous to clock
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module serial_rx_status (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // register port
    input  wire logic [4:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // serial input and system state
    input  wire logic        rx_line,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        debug_break,
    input  wire logic        break_clear_enable,
    // requests
    output logic             rx_irq,
    output logic             err_irq,
    output logic             wake_request
);
    rx_status_pkg::ctrl1_t    ctl1_r;
    rx_status_pkg::ctrl2_t    ctl2_r;
    rx_status_pkg::ctrl3_t    ctl3_r;
    rx_status_pkg::status_t   st_r, st_nxt, arm_r;
    rx_status_pkg::rx_state_t state_r, state_nxt;
    logic [7:0] baud_r, div_r, buf_r, rdata_r, ones_r;
    logic [8:0] shift_r;
    logic [4:0] rt_r, rt_nxt;
    logic [3:0] bit_r;
    logic [2:0] hist_r, samp_r;
    logic       noise_r, bitval_r, ninth_r, rx_irq_r, err_irq_r, wake_r;

    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic split3(input logic [2:0] s);
        return (s != 3'h0) && (s != 3'h7);
    endfunction

    // access and tick qualifiers
    wire acc_ok   = !wait_mode;
    wire wr_ok    = wr && acc_ok;
    wire rd_ok    = rd && acc_ok;
    wire protect  = debug_break && !break_clear_enable;
    wire tick     = ctl1_r.enable && !stop_mode && (div_r == 8'h00);
    wire rx_tick  = tick && ctl2_r.rx_enable;
    wire [2:0] s3 = {samp_r[1:0], rx_line};
    wire hunt_hit = (state_r == rx_status_pkg::hunt_s) && (hist_r == 3'h7) && !rx_line;

    // per-bit sample points
    wire samp_pt  = (rt_r >= 5'h08) && (rt_r <= rx_status_pkg::rt_stop);
    wire st_pt    = (rt_r == 5'h03) || (rt_r == 5'h05) || (rt_r == 5'h07);
    wire at_eval  = rt_r == rx_status_pkg::rt_stop;
    wire at_seven = rt_r == 5'h07;
    wire at_end   = rt_r == rx_status_pkg::rt_last;
    wire fall     = hist_r[0] && !rx_line;
    wire [3:0] nbits = ctl1_r.nine_bit ? 4'h9 : 4'h8;

    // a falling edge after a one: early edge ends the bit, late edge restarts it
    wire in_data    = state_r == rx_status_pkg::data_s;
    wire edge_early = in_data && fall && bitval_r && (rt_r >= rx_status_pkg::rt_early);
    wire edge_late  = in_data && fall && ninth_r && (rt_r <= rx_status_pkg::rt_late_max);

    // character completion at the stop sample point
    wire stop_eval = rx_tick && (state_r == rx_status_pkg::stop_s) && at_eval;
    wire stop_one  = maj3(s3);
    wire stop_nz   = split3(s3);
    wire [8:0] dbits  = ctl1_r.nine_bit ? shift_r : {1'b0, shift_r[8:1]};
    wire       msb    = ctl1_r.nine_bit ? shift_r[8] : shift_r[8];
    wire       brk    = (dbits == 9'h000) && !stop_one;
    wire       par_bad = ctl1_r.parity_en && ((^dbits) != ctl1_r.parity_odd);
    wire addr_wake = stop_eval && ctl2_r.standby_request_bit && ctl1_r.wake_sel && msb;
    wire deliver   = stop_eval && (!ctl2_r.standby_request_bit || addr_wake);
    wire ovr       = deliver && st_r.receiver_full_flag;
    wire xfer      = deliver && !st_r.receiver_full_flag;

    // idle counting: after the start bit or only once the frame is over
    wire count_one = rx_line && (ctl1_r.idle_type_bit ? (state_r == rx_status_pkg::hunt_s)
                                 : (state_r != rx_status_pkg::start_s));
    wire [7:0] idle_len = ctl1_r.nine_bit ? rx_status_pkg::idle_len9 : rx_status_pkg::idle_len8;
    wire idle_hit  = rx_tick && count_one && (ones_r == idle_len - 8'h01);
    wire idle_full = ones_r >= idle_len;
    wire idle_wake = ctl2_r.standby_request_bit && !ctl1_r.wake_sel
                     && (idle_hit || idle_full);

    // register decode
    wire sel_c1 = addr == rx_status_pkg::ctrl1_off;
    wire sel_c2 = addr == rx_status_pkg::ctrl2_off;
    wire sel_c3 = addr == rx_status_pkg::ctrl3_off;
    wire sel_s1 = addr == rx_status_pkg::status1_off;
    wire sel_db = addr == rx_status_pkg::data_off;
    wire sel_bd = addr == rx_status_pkg::baud_off;
    wire arm_step = rd_ok && sel_s1 && !protect;
    wire clr_step = rd_ok && sel_db && !protect;
    wire [7:0] rd_mux = sel_c1 ? {2'h0, ctl1_r} :
                        sel_c2 ? {4'h0, ctl2_r} :
                        sel_c3 ? {3'h0, ninth_r, ctl3_r} :
                        sel_s1 ? {2'h0, st_r} :
                        sel_db ? buf_r :
                        sel_bd ? baud_r : 8'h00;

    // flag update: set wins over the two-step clear
    always_comb begin
        st_nxt = st_r;
        if (clr_step) begin
            st_nxt = st_r & ~arm_r;
        end
        if (xfer) begin
            st_nxt.receiver_full_flag = 1'b1;
            st_nxt.framing_error_flag = st_nxt.framing_error_flag | !stop_one;
            st_nxt.noise_flag = st_nxt.noise_flag | noise_r | stop_nz;
            st_nxt.parity_error_flag = st_nxt.parity_error_flag | (par_bad && !brk);
        end
        if (ovr) begin
            st_nxt.overrun_flag = 1'b1;
        end
        if (idle_hit && !ctl2_r.standby_request_bit) begin
            st_nxt.idle_line_flag = 1'b1;
        end
    end

    // receive sequencer
    always_comb begin
        state_nxt = state_r;
        rt_nxt    = rt_r + 5'h01;
        case (state_r)
            rx_status_pkg::hunt_s: begin
                rt_nxt = hunt_hit ? 5'h02 : 5'h01;
                if (hunt_hit) begin
                    state_nxt = rx_status_pkg::start_s;
                end
            end
            rx_status_pkg::start_s: begin
                if (at_seven && maj3(s3)) begin
                    state_nxt = rx_status_pkg::hunt_s;
                    rt_nxt    = 5'h01;
                end else if (at_end) begin
                    state_nxt = rx_status_pkg::data_s;
                    rt_nxt    = 5'h01;
                end
            end
            rx_status_pkg::data_s: begin
                if (edge_early || edge_late) begin
                    rt_nxt = rx_status_pkg::rt_resync;
                end else if (at_end) begin
                    rt_nxt = 5'h01;
                end
                if ((at_end || edge_early) && (bit_r == nbits - 4'h1)) begin
                    state_nxt = rx_status_pkg::stop_s;
                end
            end
            rx_status_pkg::stop_s: begin
                if (at_eval) begin
                    state_nxt = rx_status_pkg::hunt_s;
                    rt_nxt    = 5'h01;
                end
            end
            default: begin
                state_nxt = rx_status_pkg::hunt_s;
                rt_nxt    = 5'h01;
            end
        endcase
    end

    // baud divider: one sample tick per baud_r+1 clocks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_r <= 8'h00;
        end else if (!stop_mode) begin
            div_r <= (div_r == 8'h00) ? baud_r : div_r - 8'h01;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= rx_status_pkg::hunt_s;
            rt_r    <= 5'h01;
            hist_r  <= 3'h0;
            samp_r  <= 3'h0;
        end else if (rx_tick) begin
            state_r <= state_nxt;
            rt_r    <= rt_nxt;
            hist_r  <= {hist_r[1:0], rx_line};
            if (samp_pt || (st_pt && state_r == rx_status_pkg::start_s)) begin
                samp_r <= s3;
            end
        end
    end

    // data bits, noise accumulation and the last bit value for resync
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            shift_r  <= 9'h000;
            bit_r    <= 4'h0;
            noise_r  <= 1'b0;
            bitval_r <= 1'b0;
            ninth_r  <= 1'b0;
        end else if (rx_tick) begin
            if (hunt_hit) begin
                noise_r <= 1'b0;
                bit_r   <= 4'h0;
            end
            if (state_r == rx_status_pkg::start_s && (at_seven || at_eval) && split3(s3)) begin
                noise_r <= 1'b1;
            end
            if (state_r == rx_status_pkg::start_s && at_eval && s3 != 3'h0) begin
                noise_r <= 1'b1;
            end
            if (in_data && at_eval) begin
                bitval_r <= maj3(s3);
                shift_r  <= ctl1_r.nine_bit ? {maj3(s3), shift_r[8:1]}
                                            : {maj3(s3), shift_r[8:1]};
                if (split3(s3)) begin
                    noise_r <= 1'b1;
                end
            end
            if (in_data && (at_end || edge_early)) begin
                bit_r   <= bit_r + 4'h1;
                ninth_r <= bitval_r;
            end
            if (state_r == rx_status_pkg::start_s) begin
                bitval_r <= 1'b0;
                ninth_r  <= 1'b0;
            end
        end
    end

    // consecutive-ones counter, saturating at the idle length
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ones_r <= 8'h00;
        end else if (rx_tick) begin
            ones_r <= !count_one ? 8'h00 : (idle_full ? ones_r : ones_r + 8'h01);
        end
    end

    // control registers; stop mode only freezes the tick, registers keep state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctl1_r <= '0;
            ctl2_r <= '0;
            ctl3_r <= '0;
            baud_r <= rx_status_pkg::baud_reset;
        end else begin
            if (wr_ok && sel_c1) begin
                ctl1_r <= wdata[5:0];
            end
            if (wr_ok && sel_c3) begin
                ctl3_r <= wdata[3:0];
            end
            if (wr_ok && sel_bd) begin
                baud_r <= wdata;
            end
            if (wr_ok && sel_c2) begin
                ctl2_r <= wdata[3:0];
            end else if (addr_wake || (idle_wake && rx_tick)) begin
                ctl2_r.standby_request_bit <= 1'b0;
            end
        end
    end

    // status, data buffer and arming of the two-step clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r  <= '0;
            arm_r <= '0;
            buf_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (arm_step) begin
                arm_r <= st_r;
            end else if (clr_step) begin
                arm_r <= '0;
            end
            if (xfer) begin
                buf_r <= brk ? 8'h00 : dbits[7:0];
            end
        end
    end

    // registered outputs; requests double as the wait-mode wake source
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_r   <= 8'h00;
            rx_irq_r  <= 1'b0;
            err_irq_r <= 1'b0;
            wake_r    <= 1'b0;
        end else begin
            rdata_r   <= rd_ok ? rd_mux : 8'h00;
            rx_irq_r  <= !ctl2_r.standby_request_bit
                         && ((st_r.receiver_full_flag && ctl2_r.receive_full_irq_enable)
                         || (st_r.idle_line_flag && ctl2_r.idle_irq_enable));
            err_irq_r <= (st_r.overrun_flag && ctl3_r.overrun_irq_enable)
                         || (st_r.noise_flag && ctl3_r.noise_irq_enable)
                         || (st_r.framing_error_flag && ctl3_r.framing_irq_enable)
                         || (st_r.parity_error_flag && ctl3_r.parity_irq_enable);
            wake_r    <= wait_mode && (rx_irq_r || err_irq_r);
        end
    end

    assign rdata        = rdata_r;
    assign rx_irq       = rx_irq_r;
    assign err_irq      = err_irq_r;
    assign wake_request = wake_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_fe_with_full: assert property ($rose(st_r.framing_error_flag) |-> $rose(st_r.receiver_full_flag))
        else $error("framing error rose without receiver full");
    chk_stop_point: assert property (stop_eval |-> rt_r == 5'h0a && state_r == rx_status_pkg::stop_s)
        else $error("stop evaluated off its sample point");
    chk_stop_noise: assert property (xfer && stop_nz |=> st_r.noise_flag)
        else $error("split stop samples did not flag noise");
    chk_overrun_keep: assert property (ovr |=> st_r.overrun_flag && buf_r == $past(buf_r))
        else $error("overrun changed the data buffer");
    chk_addr_wake: assert property (addr_wake && !wr_ok |=> !ctl2_r.standby_request_bit && st_r.receiver_full_flag)
        else $error("address mark did not wake");
    chk_standby_quiet: assert property (ctl2_r.standby_request_bit |=> !rx_irq_r)
        else $error("receiver request during standby");
    chk_break_hold: assert property (protect |=> ($past(st_r) & ~st_r) == 6'h00)
        else $error("status flag cleared during protected break");
    chk_wait_block: assert property (wait_mode && rd |=> rdata == 8'h00)
        else $error("register read served in wait mode");
    chk_err_gate: assert property (st_r.framing_error_flag && ctl3_r.framing_irq_enable |=> err_irq_r)
        else $error("framing error request missing");
    chk_stop_freeze: assert property (stop_mode |=> state_r == $past(state_r) && rt_r == $past(rt_r))
        else $error("receiver moved in stop mode");
endmodule

// ### tb/serial_tx_model.sv
// remote transmitter that drives the receiver's serial input
// assumes the baud divisor stays at zero, so one sample tick is one clock
`timescale 1ns/10ps
module serial_tx_model (
    // clock
    input  wire logic clock,
    // serial line
    output logic      rx_line
);
    initial rx_line = 1'b1;

    task automatic hold_bits(input logic b, input int n);
        rx_line <= b;
        repeat (n) @(posedge clock);
    endtask

    // stop_kind: 0 clean stop, 1 one low stop sample, 2 stop held low
    task automatic send(input logic [8:0] data, input int nbits, input int stop_kind);
        int i;
        // a few ones first so the start edge is seen after a quiet line
        hold_bits(1'b1, 4);
        hold_bits(1'b0, 16);
        for (i = 0; i < nbits; i++) begin
            hold_bits(data[i], 16);
        end
        if (stop_kind == 1) begin
            hold_bits(1'b1, 8);
            hold_bits(1'b0, 1);
            hold_bits(1'b1, 7);
        end else begin
            hold_bits(stop_kind != 2, 16);
        end
        rx_line <= 1'b1;
    endtask

    // slow transmitter: 17 ticks per bit, drifts one tick per bit without realignment
    task automatic send_slow(input logic [7:0] data);
        int i;
        hold_bits(1'b1, 4);
        hold_bits(1'b0, 17);
        for (i = 0; i < 8; i++) begin
            hold_bits(data[i], 17);
        end
        hold_bits(1'b1, 17);
        rx_line <= 1'b1;
    endtask
endmodule

// ### tb/async_serial_receiver_status_bench.sv
// self-checking bench of the serial receiver status block
// assumes the transmitter model drives rx_line; registers reset to zero
`timescale 1ns/10ps
module async_serial_receiver_status_bench;
    logic       clock;
    logic       resetn;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       rx_line;
    logic       wait_mode;
    logic       stop_mode;
    logic       debug_break;
    logic       bce;
    logic       rx_irq;
    logic       err_irq;
    logic       wake_request;
    logic [7:0] got;
    int         error_cnt;
    int         checks_done;

    serial_rx_status dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx_line(rx_line), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .debug_break(debug_break), .break_clear_enable(bce),
        .rx_irq(rx_irq), .err_irq(err_irq), .wake_request(wake_request));

    serial_tx_model tx (.clock(clock), .rx_line(rx_line));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        // sampled at the next edge, before the design replaces the registered value
        @(posedge clock);
        got = rdata;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        rd_reg(a);
        check(got, exp);
    endtask

    // status read then buffer read clears the armed flags
    task automatic clear_flags;
        rd_reg(rx_status_pkg::status1_off);
        rd_reg(rx_status_pkg::data_off);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        give_verdict();
    end

    initial begin
        error_cnt = 0;
        checks_done = 0;
        resetn = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wait_mode = 1'b0;
        stop_mode = 1'b0;
        debug_break = 1'b0;
        bce = 1'b0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd_chk(rx_status_pkg::ctrl1_off, 8'h00);
        rd_chk(rx_status_pkg::ctrl3_off, 8'h00);
        rd_chk(rx_status_pkg::status1_off, 8'h00);
        rd_chk(5'h18, 8'h00);
        $display("test reset done");
        wr_reg(rx_status_pkg::ctrl1_off, 8'h20);
        wr_reg(rx_status_pkg::ctrl2_off, 8'h0a);
        tx.send(9'h0a5, 8, 0);
        rd_chk(rx_status_pkg::status1_off, 8'h20);
        check({7'h00, rx_irq}, 8'h01);
        rd_chk(rx_status_pkg::data_off, 8'ha5);
        rd_chk(rx_status_pkg::status1_off, 8'h00);
        check({7'h00, rx_irq}, 8'h00);
        $display("test receive done");
        tx.send(9'h03c, 8, 2);
        rd_chk(rx_status_pkg::status1_off, 8'h22);
        check({7'h00, err_irq}, 8'h00);
        wr_reg(rx_status_pkg::ctrl3_off, 8'h02);
        rd_chk(rx_status_pkg::ctrl3_off, 8'h02);
        check({7'h00, err_irq}, 8'h01);
        clear_flags();
        wr_reg(rx_status_pkg::ctrl3_off, 8'h0f);
        tx.send(9'h000, 8, 2);
        rd_chk(rx_status_pkg::status1_off, 8'h22);
        clear_flags();
        tx.send(9'h0a5, 8, 1);
        rd_chk(rx_status_pkg::status1_off, 8'h24);
        check({7'h00, err_irq}, 8'h01);
        clear_flags();
        $display("test stop bit done");
        // bits one tick longer each: only the realignment keeps the stop clean
        tx.send_slow(8'h55);
        rd_chk(rx_status_pkg::status1_off, 8'h20);
        rd_chk(rx_status_pkg::data_off, 8'h55);
        tx.send(9'h0a5, 8, 0);
        tx.send(9'h03c, 8, 0);
        rd_chk(rx_status_pkg::status1_off, 8'h28);
        rd_chk(rx_status_pkg::data_off, 8'ha5);
        wr_reg(rx_status_pkg::ctrl1_off, 8'h22);
        tx.send(9'h001, 8, 0);
        rd_chk(rx_status_pkg::status1_off, 8'h21);
        clear_flags();
        wr_reg(rx_status_pkg::ctrl1_off, 8'h20);
        $display("test errors done");
        tx.send(9'h0a5, 8, 0);
        @(posedge clock);
        wait_mode <= 1'b1;
        wr_reg(rx_status_pkg::ctrl2_off, 8'h00);
        rd_chk(rx_status_pkg::ctrl2_off, 8'h00);
        check({7'h00, wake_request}, 8'h01);
        @(posedge clock);
        wait_mode <= 1'b0;
        rd_chk(rx_status_pkg::ctrl2_off, 8'h0a);
        clear_flags();
        $display("test wait done");
        tx.send(9'h03c, 8, 2);
        rd_reg(rx_status_pkg::status1_off);
        debug_break <= 1'b1;
        rd_reg(rx_status_pkg::data_off);
        rd_chk(rx_status_pkg::status1_off, 8'h22);
        debug_break <= 1'b0;
        rd_reg(rx_status_pkg::data_off);
        rd_chk(rx_status_pkg::status1_off, 8'h00);
        tx.send(9'h03c, 8, 2);
        bce <= 1'b1;
        debug_break <= 1'b1;
        clear_flags();
        rd_chk(rx_status_pkg::status1_off, 8'h00);
        debug_break <= 1'b0;
        bce <= 1'b0;
        rd_chk(rx_status_pkg::status1_off, 8'h00);
        $display("test break done");
        wr_reg(rx_status_pkg::ctrl1_off, 8'h28);
        wr_reg(rx_status_pkg::ctrl2_off, 8'h0b);
        tx.send(9'h012, 8, 0);
        rd_chk(rx_status_pkg::status1_off, 8'h00);
        check({7'h00, rx_irq}, 8'h00);
        tx.send(9'h092, 8, 0);
        rd_chk(rx_status_pkg::status1_off, 8'h20);
        rd_chk(rx_status_pkg::ctrl2_off, 8'h0a);
        rd_chk(rx_status_pkg::data_off, 8'h92);
        // the address does not match ours, so go back to standby
        wr_reg(rx_status_pkg::ctrl2_off, 8'h0b);
        wr_reg(rx_status_pkg::ctrl1_off, 8'h20);
        repeat (200) @(posedge clock);
        rd_chk(rx_status_pkg::ctrl2_off, 8'h0a);
        rd_chk(rx_status_pkg::status1_off, 8'h00);
        $display("test wakeup done");
        wr_reg(rx_status_pkg::ctrl2_off, 8'h0e);
        tx.send(9'h0a5, 8, 0);
        clear_flags();
        repeat (200) @(posedge clock);
        rd_chk(rx_status_pkg::status1_off, 8'h10);
        check({7'h00, rx_irq}, 8'h01);
        wr_reg(rx_status_pkg::ctrl2_off, 8'h0a);
        rd_chk(rx_status_pkg::ctrl2_off, 8'h0a);
        check({7'h00, rx_irq}, 8'h00);
        @(posedge clock);
        stop_mode <= 1'b1;
        rd_chk(rx_status_pkg::ctrl2_off, 8'h0a);
        rd_chk(rx_status_pkg::status1_off, 8'h10);
        stop_mode <= 1'b0;
        $display("test idle and stop done");
        give_verdict();
    end
endmodule
